/* File: logic/fves_top.sv */
// design: fpu and vector fp exception signalling with apb registers
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fves_top
  import fves_pkg::*;
#(
  parameter int LANES = 4,
  parameter int TAG_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // scalar fpu side (core clock, no synchroniser)
  input wire logic fpu_exc_valid,
  input wire logic insn_valid,
  input wire logic insn_is_wait_fpu,
  input wire logic insn_is_nowait,
  input wire logic insn_is_nowait_save,
  input wire logic insn_dna_fault,
  input wire logic [TAG_W-1:0] insn_tag,
  // vector fp side
  input wire logic vfp_valid,
  input wire logic vfp_packed,
  input wire logic [TAG_W-1:0] vfp_tag,
  input wire logic [LANES*NUM_EXC-1:0] vfp_lane_exc,
  input wire logic multiproc_mode,
  input wire logic gate_is_interrupt,
  // outputs
  output logic exc_take,
  output logic [7:0] exc_vector,
  output logic [TAG_W-1:0] exc_tag,
  output logic fpu_error_out_n,
  output logic irq
);
  import fves_pkg::*;

  // ==========================================================
  // state
  logic [31:0] ctrl_q;
  logic [31:0] vcsr_q;
  logic [31:0] flags_q;
  logic [NUM_ST-1:0] status_q;
  logic [NUM_ST-1:0] irq_en_q;
  logic fpu_pend_q;
  logic [1:0] pulse_cnt_q;
  logic err_asserted_q;

  logic native_error_mode;
  assign native_error_mode = ctrl_q[CTRL_NE_BIT];

  // ==========================================================
  // vector fp lane folding
  logic [NUM_EXC-1:0] vfp_or;
  logic [NUM_EXC-1:0] vfp_masks;
  logic [NUM_EXC-1:0] vfp_unmasked;
  always_comb begin
    vfp_or = '0;
    for (int l = 0; l < LANES; l++) begin
      // only lane 0 counts for scalar ops; lane identity is dropped
      if (vfp_packed || l == 0) begin
        vfp_or = vfp_or | vfp_lane_exc[l*NUM_EXC +: NUM_EXC];
      end
    end
  end
  assign vfp_masks = vcsr_q[VCSR_MASK_LSB +: NUM_EXC];
  // only this instruction's new exceptions count, never old flags
  assign vfp_unmasked = vfp_or & ~vfp_masks;

  // ==========================================================
  // event decode
  logic wait_insn;
  logic dna_take;
  logic fpu_take;
  logic vfp_take;
  logic save_pulse;
  logic apb_wr;
  logic apb_rd;
  assign wait_insn = insn_valid && insn_is_wait_fpu && !insn_is_nowait;
  assign dna_take = insn_valid && insn_dna_fault;
  // a no-wait instruction never takes the pending exception
  assign fpu_take = wait_insn && !dna_take && fpu_pend_q
    && native_error_mode;
  // vector exceptions are taken on their own instruction, same cycle
  assign vfp_take = vfp_valid && (vfp_unmasked != '0);
  assign save_pulse = insn_valid && insn_is_nowait_save
    && fpu_pend_q;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  // ==========================================================
  // pending scalar exception
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fpu_pend_q <= 1'b0;
    end else if (fpu_exc_valid) begin
      fpu_pend_q <= 1'b1;
    end else if (fpu_take) begin
      fpu_pend_q <= 1'b0;
    end
  end

  // ==========================================================
  // error output: same point either mode; multiprocessor hides it
  logic err_level;
  logic err_wait_hit;
  logic err_pulse_on;
  logic err_drive;
  // a waiting instruction that meets a pending exception
  assign err_wait_hit = fpu_pend_q && wait_insn;
  // compatibility mode holds the pin while the exception is pending
  assign err_level = fpu_pend_q && err_asserted_q && !fpu_take;
  // the no-wait save pulse is stretched so slow pickup still sees it
  assign err_pulse_on = save_pulse || (pulse_cnt_q != '0);
  // the wire serves only compatibility systems, hence the mp gate
  assign err_drive = (err_wait_hit || err_level || err_pulse_on)
    && !multiproc_mode;
  // the pin is registered so it never glitches between edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_asserted_q <= 1'b0;
      pulse_cnt_q <= '0;
      fpu_error_out_n <= 1'b1;
    end else begin
      err_asserted_q <= (err_wait_hit || err_asserted_q) && fpu_pend_q
        && !native_error_mode;
      if (save_pulse) begin
        pulse_cnt_q <= 2'(NOWAIT_PULSE_CYC);
      end else if (pulse_cnt_q != '0) begin
        pulse_cnt_q <= pulse_cnt_q - 2'd1;
      end
      fpu_error_out_n <= !err_drive;
    end
  end

  // ==========================================================
  // exception dispatch, one cycle, dna first then vector then fpu
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exc_take <= 1'b0;
      exc_vector <= '0;
      exc_tag <= '0;
    end else begin
      exc_take <= dna_take || vfp_take || fpu_take;
      if (dna_take) begin
        exc_vector <= VEC_DNA;
        exc_tag <= insn_tag;
      end else if (vfp_take) begin
        exc_vector <= VEC_VFP;
        exc_tag <= vfp_tag;
      end else if (fpu_take) begin
        exc_vector <= VEC_FPU;
        exc_tag <= insn_tag;
      end
    end
  end

  // ==========================================================
  // control register zero and flags register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
    end else if (apb_wr && paddr == ADDR_CTRL) begin
      ctrl_q <= pwdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= FLAGS_RST;
    end else if ((dna_take || vfp_take || fpu_take)
        && gate_is_interrupt) begin
      flags_q[FLAGS_IF_BIT] <= 1'b0;
    end else if (apb_wr && paddr == ADDR_FLAGS) begin
      flags_q <= pwdata;
    end
  end

  // ==========================================================
  // vector control/status: sticky flags, set wins over write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vcsr_q <= VCSR_RST;
    end else begin
      if (apb_wr && paddr == ADDR_VCSR) begin
        vcsr_q <= pwdata;
        if (vfp_valid) begin
          vcsr_q[NUM_EXC-1:0] <= pwdata[NUM_EXC-1:0] | vfp_or;
        end
      end else if (vfp_valid) begin
        vcsr_q[NUM_EXC-1:0] <= vcsr_q[NUM_EXC-1:0] | vfp_or;
      end
    end
  end

  // ==========================================================
  // apb address decode, one hit per register
  // unmapped offsets answer with an error and change nothing
  // paddr is compared whole: misaligned offsets count as unmapped
  logic hit_ctrl;
  logic hit_vcsr;
  logic hit_status;
  logic hit_irq_en;
  logic hit_irq_clr;
  logic hit_flags;
  logic known;
  assign hit_ctrl = (paddr == ADDR_CTRL);
  assign hit_vcsr = (paddr == ADDR_VCSR);
  assign hit_status = (paddr == ADDR_STATUS);
  assign hit_irq_en = (paddr == ADDR_IRQ_EN);
  assign hit_irq_clr = (paddr == ADDR_IRQ_CLR);
  assign hit_flags = (paddr == ADDR_FLAGS);
  assign known = hit_ctrl || hit_vcsr || hit_status || hit_irq_en
    || hit_irq_clr || hit_flags;

  // ==========================================================
  // interrupt status / enable / clear
  // each event sets a sticky status bit; software writes ones to the
  // clear register to drop them, and irq is their enabled or
  logic [NUM_ST-1:0] ev;
  logic [NUM_ST-1:0] irq_clr;
  logic [NUM_ST-1:0] status_d;
  logic [NUM_ST-1:0] irq_en_d;

  always_comb begin
    ev = '0;
    ev[ST_FPU_EXC] = fpu_take;
    ev[ST_VFP_EXC] = vfp_take;
    ev[ST_DNA] = dna_take;
    ev[ST_NOWAIT_PULSE] = save_pulse;
  end

  // write-one-to-clear strobe, only in the access cycle
  always_comb begin
    irq_clr = '0;
    if (apb_wr && hit_irq_clr) begin
      irq_clr = pwdata[NUM_ST-1:0];
    end
  end

  // a new event in the clearing cycle is kept: set wins
  always_comb begin
    status_d = (status_q & ~irq_clr) | ev;
  end

  // enable register keeps its value unless written
  always_comb begin
    irq_en_d = irq_en_q;
    if (apb_wr && hit_irq_en) begin
      irq_en_d = pwdata[NUM_ST-1:0];
    end
  end

  // status is read-only: a write to its offset is accepted and dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_q <= '0;
    end else begin
      irq_en_q <= irq_en_d;
    end
  end

  // built from the next values so irq follows an enable or clear
  // write at once instead of trailing it by one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_d & irq_en_d);
    end
  end

  // ==========================================================
  // apb slave: zero wait, read data registered in setup cycle
  // the clear register is write-only and reads as zero
  logic [31:0] prdata_d;

  always_comb begin
    prdata_d = '0;
    unique case (paddr)
      ADDR_CTRL: prdata_d = ctrl_q;
      ADDR_VCSR: prdata_d = vcsr_q;
      ADDR_STATUS: prdata_d = {{(32-NUM_ST){1'b0}}, status_q};
      ADDR_IRQ_EN: prdata_d = {{(32-NUM_ST){1'b0}}, irq_en_q};
      ADDR_IRQ_CLR: prdata_d = '0;
      ADDR_FLAGS: prdata_d = flags_q;
      default: prdata_d = '0;
    endcase
  end

  // pready answers each setup one cycle later: there are no wait
  // states, so a master that waits for pready never stalls here
  // pslverr only ever rides along with pready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known;
      if (apb_rd) begin
        prdata <= prdata_d;
      end
    end
  end
endmodule // fves_top
`default_nettype wire

/* File: common/fves_pkg.sv */
// package: constants for the fpu / vector fp exception signalling block
package fves_pkg;
  // ==========================================================
  // register map (apb byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_VCSR = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;
  // ==========================================================
  // field positions
  localparam int CTRL_NE_BIT = 5;
  localparam int VCSR_MASK_LSB = 7;
  localparam int FLAGS_IF_BIT = 9;
  localparam int NUM_EXC = 6;
  // ==========================================================
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] VCSR_RST = 32'h0000_1f80;
  localparam logic [31:0] FLAGS_RST = 32'h0000_0202;
  // ==========================================================
  // exception vectors
  localparam logic [7:0] VEC_FPU = 8'h10;
  localparam logic [7:0] VEC_VFP = 8'h13;
  localparam logic [7:0] VEC_DNA = 8'h07;
  // ==========================================================
  // status / interrupt bits
  localparam int ST_FPU_EXC = 0;
  localparam int ST_VFP_EXC = 1;
  localparam int ST_DNA = 2;
  localparam int ST_NOWAIT_PULSE = 3;
  localparam int NUM_ST = 4;
  // ==========================================================
  // timing: the error pulse on a no-wait save outlasts the save cycle by 20 ns, 30 ns in all
  localparam int NOWAIT_PULSE_NS = 20;
  localparam int CLK_PERIOD_NS = 10;
  localparam int NOWAIT_PULSE_CYC =
    (NOWAIT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* File: verification/fves_properties.sv */
// checker: port-level properties of the exception signalling block
`timescale 1ns/1ps
`default_nettype none
module fves_properties
  import fves_pkg::*;
#(parameter int LANES = 4, parameter int TAG_W = 8) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fpu_exc_valid,
  input wire logic insn_valid,
  input wire logic insn_is_wait_fpu,
  input wire logic insn_is_nowait,
  input wire logic insn_is_nowait_save,
  input wire logic insn_dna_fault,
  input wire logic [TAG_W-1:0] insn_tag,
  input wire logic vfp_valid,
  input wire logic [TAG_W-1:0] vfp_tag,
  input wire logic [LANES*NUM_EXC-1:0] vfp_lane_exc,
  input wire logic multiproc_mode,
  input wire logic exc_take,
  input wire logic [7:0] exc_vector,
  input wire logic [TAG_W-1:0] exc_tag,
  input wire logic fpu_error_out_n
);
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_dna; insn_valid && insn_dna_fault |=> exc_take &&
    exc_vector == VEC_DNA && exc_tag == $past(insn_tag); endproperty
  a_dna: assert property (p_dna) else $error("dna late");
  property p_vtag; vfp_valid && !insn_valid |=> !exc_take ||
    (exc_vector == VEC_VFP && exc_tag == $past(vfp_tag)); endproperty
  a_vtag: assert property (p_vtag) else $error("bad vec tag");
  property p_noexc; vfp_valid && vfp_lane_exc == '0 && !insn_valid
    |=> !exc_take; endproperty
  a_noexc: assert property (p_noexc) else $error("spurious");
  property p_nowait; insn_valid && (insn_is_nowait || insn_is_nowait_save)
    |=> !(exc_take && exc_vector == VEC_FPU); endproperty
  a_nowait: assert property (p_nowait) else $error("nowait 16");
  // pending numeric exception seen by a waiting instruction drives the pin
  property p_pin; fpu_exc_valid ##1 (insn_valid && insn_is_wait_fpu &&
    !insn_is_nowait && !multiproc_mode) |=> !fpu_error_out_n; endproperty
  a_pin: assert property (p_pin) else $error("pin idle");
  property p_save; fpu_exc_valid ##1 (insn_valid && insn_is_nowait_save &&
    !multiproc_mode) |=> !fpu_error_out_n [*2]; endproperty
  a_save: assert property (p_save) else $error("no pulse");
  property p_mp; multiproc_mode [*2] |-> fpu_error_out_n; endproperty
  a_mp: assert property (p_mp) else $error("mp pin");
  // a take needs an event one cycle before, nothing may trail in later
  property p_late; !insn_valid && !vfp_valid |=> !exc_take; endproperty
  a_late: assert property (p_late) else $error("late take");
  c_dna: cover property (exc_take && exc_vector == VEC_DNA);
  c_vfp: cover property (exc_take && exc_vector == VEC_VFP);
  c_fpu: cover property (exc_take && exc_vector == VEC_FPU);
endmodule // fves_properties
`default_nettype wire

/* File: verification/fves_os_model.sv */
// partner: interrupt controller routing of the legacy error line
`timescale 1ns/1ps
`default_nettype none
module fves_os_model (
  input wire logic native,
  input wire logic fpu_error_out_n,
  output logic legacy_fpu_irq_line
);
  // ==========================================================
  // line kept disabled in native mode, else a duplicate interrupt
  assign legacy_fpu_irq_line = !native && !fpu_error_out_n;
endmodule // fves_os_model
`default_nettype wire

/* File: verification/tb_top.sv */
// testbench: directed and random checks of the exception block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fves_pkg::*;
  localparam int LANES = 4;
  localparam int TAG_W = 8;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, native = 0;
  logic fpu_exc_valid = 0, insn_valid = 0, insn_is_wait_fpu = 0;
  logic insn_is_nowait = 0, insn_is_nowait_save = 0, insn_dna_fault = 0;
  logic vfp_valid = 0, vfp_packed = 0, multiproc_mode = 0;
  logic gate_is_interrupt = 0, pready, pslverr, exc_take;
  logic fpu_error_out_n, irq, legacy_irq;
  logic [7:0] paddr = '0, insn_tag = '0, vfp_tag = '0, exc_vector, exc_tag, t;
  logic [31:0] pwdata = '0, prdata, f;
  logic [23:0] vfp_lane_exc = '0, e;
  logic [31:0] q[$];
  logic [31:0] eq[$];
  int fail_count = 0, checked = 0;
  // ==========================================================
  always #5 clk = ~clk;
  fves_top u_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fpu_exc_valid, .insn_valid,
    .insn_is_wait_fpu, .insn_is_nowait, .insn_is_nowait_save, .insn_dna_fault,
    .insn_tag, .vfp_valid, .vfp_packed, .vfp_tag, .vfp_lane_exc,
    .multiproc_mode, .gate_is_interrupt, .exc_take, .exc_vector, .exc_tag,
    .fpu_error_out_n, .irq);
  fves_os_model u_os (.native, .fpu_error_out_n,
    .legacy_fpu_irq_line(legacy_irq));
  task chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  function automatic logic [31:0] pop();
    return q.size() ? q.pop_front() : '1;
  endfunction
  // an unexpected access finds the error queue empty and fails
  function automatic logic [31:0] pope();
    return eq.size() ? eq.pop_front() : '1;
  endfunction
  always @(posedge clk) begin
    if (exc_take) chk({16'h0, exc_vector, exc_tag}, pop());
    if (psel && penable && pready && !pwrite) chk(prdata, pop());
    if (psel && penable && pready) chk({31'h0, pslverr}, pope());
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    eq.push_back(32'(!(a inside {ADDR_CTRL, ADDR_VCSR, ADDR_STATUS,
      ADDR_IRQ_EN, ADDR_IRQ_CLR, ADDR_FLAGS})));
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1;
    @(posedge clk iff pready) psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    q.push_back(x);
    apb(0, a, 0);
  endtask
  task ins(input logic [3:0] k, input logic [7:0] tg);
    insn_valid <= 1; insn_tag <= tg;
    {insn_is_wait_fpu, insn_is_nowait, insn_is_nowait_save,
      insn_dna_fault} <= k;
    @(posedge clk) insn_valid <= 0;
    repeat (3) @(posedge clk);
  endtask
  task tk(input logic [3:0] k, input logic [7:0] v);
    t = 8'($urandom);
    q.push_back({16'h0, v, t});
    ins(k, t);
  endtask
  task vt;
    t = 8'($urandom);
    q.push_back({16'h0, VEC_VFP, t});
    vfp_valid <= 1; vfp_packed <= 1; vfp_lane_exc <= e; vfp_tag <= t;
    @(posedge clk) vfp_valid <= 0;
    repeat (3) @(posedge clk);
  endtask
  task fexc;
    fpu_exc_valid <= 1;
    @(posedge clk) fpu_exc_valid <= 0;
  endtask
  task print_verdict;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    print_verdict;
  end
  initial begin
    void'($urandom(10188));
    repeat (6) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rd(ADDR_VCSR, VCSR_RST);
    rd(8'h40, 32'h0);
    apb(1, ADDR_CTRL, 32'h1 << CTRL_NE_BIT);
    native = 1;
    fexc;
    ins(4'b0110, 8'h0);
    ins(4'b0100, 8'h0);
    tk(4'b1000, VEC_FPU);
    fexc;
    tk(4'b1001, VEC_DNA);
    tk(4'b1000, VEC_FPU);
    e = 24'($urandom | 1);
    ins(4'b0000, 8'h0);
    vfp_valid <= 1; vfp_packed <= 1; vfp_lane_exc <= e; vfp_tag <= 0;
    @(posedge clk) vfp_valid <= 0;
    repeat (3) @(posedge clk);
    f = 32'(e[5:0] | e[11:6] | e[17:12] | e[23:18]);
    rd(ADDR_VCSR, VCSR_RST | f);
    apb(1, ADDR_VCSR, f);
    // old flags with masks clear and no new lane exception: no take
    vfp_valid <= 1; vfp_lane_exc <= '0;
    @(posedge clk) vfp_valid <= 0;
    repeat (3) @(posedge clk);
    vt;
    rd(ADDR_STATUS, 32'hf);
    chk({31'h0, irq}, 32'h0);
    apb(1, ADDR_IRQ_EN, 32'h1 << ST_VFP_EXC);
    chk({31'h0, irq}, 32'h1);
    apb(1, ADDR_IRQ_CLR, 32'h1 << ST_VFP_EXC);
    chk({31'h0, irq}, 32'h0);
    gate_is_interrupt <= 1;
    vt;
    rd(ADDR_FLAGS, FLAGS_RST & ~(32'h1 << FLAGS_IF_BIT));
    // compatibility mode: no internal take, pin and legacy line active
    apb(1, ADDR_CTRL, 32'h0);
    native = 0;
    fexc;
    ins(4'b1000, 8'h0);
    chk({31'h0, fpu_error_out_n}, 32'h0);
    chk({31'h0, legacy_irq}, 32'h1);
    apb(1, ADDR_CTRL, 32'h1 << CTRL_NE_BIT);
    native = 1;
    multiproc_mode <= 1;
    fexc;
    tk(4'b1000, VEC_FPU);
    chk({31'h0, fpu_error_out_n}, 32'h1);
    chk({31'h0, legacy_irq}, 32'h0);
    chk(q.size(), 0);
    print_verdict;
  end
endmodule // tb_top
bind fves_top fves_properties #(.LANES(LANES), .TAG_W(TAG_W)) u_props (.clk,
  .rst_n, .fpu_exc_valid, .insn_valid, .insn_is_wait_fpu, .insn_is_nowait,
  .insn_is_nowait_save, .insn_dna_fault, .insn_tag, .vfp_valid, .vfp_tag,
  .vfp_lane_exc, .multiproc_mode, .exc_take, .exc_vector, .exc_tag,
  .fpu_error_out_n);
`default_nettype wire
